// *** hdl/mii_lat_cfg.svh ***
// constants for the media independent interface latency datapath
// Functional notes
// - crs rises about four bit times after tx_en is seen high
// - crs falls about four bit times after tx_en low, unless receiving
// - encoded transmit symbols reach the line about seven bit times after tx_en
// - first receive nibble follows crs within one to three bit times
// - start-of-stream delimiter raises crs after about 140 ns
// - end-of-stream delimiter drops crs after about 170 ns
// - rxd, rx_er, rx_dv change away from the rising edge of rxc
`ifndef MII_LAT_CFG_SVH
`define MII_LAT_CFG_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define BIT_TIME_NS 10
`define TX_CRS_BT 4
`define TX_LAT_BT 7
`define SSD_CRS_NS 140
`define ESD_CRS_NS 170
// least time, rounded up to whole cycles, never below one
`define NS_TO_CYC(ns) \
   ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
    (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define TX_CRS_CYC `NS_TO_CYC(`TX_CRS_BT * `BIT_TIME_NS)
`define TX_LAT_CYC `NS_TO_CYC(`TX_LAT_BT * `BIT_TIME_NS)
`define SSD_CRS_CYC `NS_TO_CYC(`SSD_CRS_NS)
`define ESD_CRS_CYC `NS_TO_CYC(`ESD_CRS_NS)
// link clock: eight system cycles per period, four per half
`define LINK_HALF_CYC 4

// ---------------------------------------------------------------
// line code groups
// ---------------------------------------------------------------
`define CODE_IDLE 5'h1F
`define CODE_J 5'h18
`define CODE_K 5'h11
`define CODE_T 5'h0D
`define CODE_R 5'h07
`define CODE_H 5'h04

`endif

// *** hdl/mii_lat_pkg.sv ***
// types shared by the mii latency datapath
package mii_lat_pkg;
   typedef struct packed {
      logic en;
      logic er;
      logic [3:0] d;
   } mii_tx_s;
   typedef struct packed {
      logic dv;
      logic er;
      logic [3:0] d;
   } mii_rx_s;
   typedef enum logic [1:0] {
      RX_IDLE,
      RX_GOT_J,
      RX_DATA
   } rx_state_e;
endpackage

// *** hdl/code_4b5b.sv ***
// 4b/5b encoder and decoder
`timescale 1ns/1ps
`include "mii_lat_cfg.svh"
module code_4b5b (
   // encoder
   input wire logic [3:0] enc_nib,
   output logic [4:0] enc_code,
   // decoder
   input wire logic [4:0] dec_code,
   output logic [3:0] dec_nib,
   output logic dec_ok
);
   always_comb begin
      case (enc_nib)
         4'h0: enc_code = 5'h1E;
         4'h1: enc_code = 5'h09;
         4'h2: enc_code = 5'h14;
         4'h3: enc_code = 5'h15;
         4'h4: enc_code = 5'h0A;
         4'h5: enc_code = 5'h0B;
         4'h6: enc_code = 5'h0E;
         4'h7: enc_code = 5'h0F;
         4'h8: enc_code = 5'h12;
         4'h9: enc_code = 5'h13;
         4'hA: enc_code = 5'h16;
         4'hB: enc_code = 5'h17;
         4'hC: enc_code = 5'h1A;
         4'hD: enc_code = 5'h1B;
         4'hE: enc_code = 5'h1C;
         default: enc_code = 5'h1D;
      endcase
   end

   always_comb begin
      dec_ok = 1'b1;
      case (dec_code)
         5'h1E: dec_nib = 4'h0;
         5'h09: dec_nib = 4'h1;
         5'h14: dec_nib = 4'h2;
         5'h15: dec_nib = 4'h3;
         5'h0A: dec_nib = 4'h4;
         5'h0B: dec_nib = 4'h5;
         5'h0E: dec_nib = 4'h6;
         5'h0F: dec_nib = 4'h7;
         5'h12: dec_nib = 4'h8;
         5'h13: dec_nib = 4'h9;
         5'h16: dec_nib = 4'hA;
         5'h17: dec_nib = 4'hB;
         5'h1A: dec_nib = 4'hC;
         5'h1B: dec_nib = 4'hD;
         5'h1C: dec_nib = 4'hE;
         5'h1D: dec_nib = 4'hF;
         default: begin
            dec_nib = 4'h0;
            dec_ok = 1'b0;
         end
      endcase
   end
endmodule

// *** hdl/mii_tx_rx_latency.sv ***
// mii 100 Mbit/s transmit and receive datapath with carrier sense timing
`timescale 1ns/1ps
`include "mii_lat_cfg.svh"
module mii_tx_rx_latency
   import mii_lat_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // mii clocks made by this device
   output logic txc,
   output logic rxc,
   // mii transmit pins from the mac
   input wire logic tx_en,
   input wire logic tx_er,
   input wire logic [3:0] txd,
   // mii receive pins to the mac
   output logic rx_dv,
   output logic rx_er,
   output logic [3:0] rxd,
   output logic crs,
   // line side, symbol interface of the analog front end
   output logic [4:0] line_tx_code,
   output logic line_tx_active,
   input wire logic [4:0] line_rx_code,
   input wire logic line_rx_stb
);
   // ---------------------------------------------------------------
   // link clock divider
   // ---------------------------------------------------------------
   logic [2:0] div_reg;
   logic link_clk_reg;
   logic rise_reg;
   logic rise_d_reg;
   logic fall_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_reg <= 3'h0;
         link_clk_reg <= 1'b0;
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
      end else begin
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
         if (div_reg == 3'(`LINK_HALF_CYC - 1)) begin
            div_reg <= 3'h0;
            link_clk_reg <= ~link_clk_reg;
            rise_reg <= ~link_clk_reg;
            fall_reg <= link_clk_reg;
         end else begin
            div_reg <= div_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rise_d_reg <= 1'b0;
      end else begin
         rise_d_reg <= rise_reg;
      end
   end

   assign txc = link_clk_reg;
   assign rxc = link_clk_reg;

   // ---------------------------------------------------------------
   // transmit pin capture
   // ---------------------------------------------------------------
   mii_tx_s tx_meta_reg;
   mii_tx_s tx_sync_reg;
   mii_tx_s tx_smp_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_meta_reg <= '0;
         tx_sync_reg <= '0;
      end else begin
         tx_meta_reg <= '{en: tx_en, er: tx_er, d: txd};
         tx_sync_reg <= tx_meta_reg;
      end
   end

   // the pins held at the rising txc edge reach the second stage two
   // cycles later; taking them then is what a zero hold time allows
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_smp_reg <= '0;
      end else if (rise_d_reg) begin
         tx_smp_reg <= tx_sync_reg;
      end
   end

   // ---------------------------------------------------------------
   // transmit latency to the line and transmit carrier sense
   // ---------------------------------------------------------------
   logic [4:0] enc_code;
   logic [3:0] dec_nib;
   logic dec_ok;

   code_4b5b u_code (
      .enc_nib(tx_smp_reg.d),
      .enc_code(enc_code),
      .dec_code(line_rx_code),
      .dec_nib(dec_nib),
      .dec_ok(dec_ok)
   );

   // bit_time latencies all fall below one system cycle, so each
   // becomes a single-cycle delay stage
   logic [`TX_LAT_CYC-1:0] tx_act_pipe;
   logic [`TX_CRS_CYC-1:0] tx_crs_pipe;
   logic [4:0] tx_code_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_act_pipe <= '0;
         tx_code_reg <= `CODE_IDLE;
      end else begin
         tx_act_pipe <= `TX_LAT_CYC'({tx_act_pipe, tx_smp_reg.en});
         if (!tx_smp_reg.en) begin
            tx_code_reg <= `CODE_IDLE;
         end else if (tx_smp_reg.er) begin
            tx_code_reg <= `CODE_H;
         end else begin
            tx_code_reg <= enc_code;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_crs_pipe <= '0;
      end else begin
         tx_crs_pipe <= `TX_CRS_CYC'({tx_crs_pipe, tx_smp_reg.en});
      end
   end

   assign line_tx_code = tx_code_reg;
   assign line_tx_active = tx_act_pipe[`TX_LAT_CYC-1];

   // ---------------------------------------------------------------
   // receive delimiter detection
   // ---------------------------------------------------------------
   rx_state_e rx_state_reg;
   logic [3:0] rx_nib_reg;
   logic rx_nib_pend_reg;
   logic rx_nib_err_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_state_reg <= RX_IDLE;
      end else if (line_rx_stb) begin
         case (rx_state_reg)
            RX_IDLE: begin
               if (line_rx_code == `CODE_J) begin
                  rx_state_reg <= RX_GOT_J;
               end
            end
            RX_GOT_J: begin
               if (line_rx_code == `CODE_K) begin
                  rx_state_reg <= RX_DATA;
               end else begin
                  rx_state_reg <= RX_IDLE;
               end
            end
            RX_DATA: begin
               if (line_rx_code == `CODE_T ||
                   line_rx_code == `CODE_IDLE) begin
                  rx_state_reg <= RX_IDLE;
               end
            end
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
   end

   // decoded nibbles wait here for the next falling rxc edge; a newer
   // symbol overwrites an unsent one, as the line and mii rates match
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_nib_reg <= 4'h0;
         rx_nib_pend_reg <= 1'b0;
         rx_nib_err_reg <= 1'b0;
      end else if (line_rx_stb && rx_state_reg == RX_DATA &&
                   line_rx_code != `CODE_T &&
                   line_rx_code != `CODE_IDLE) begin
         rx_nib_reg <= dec_nib;
         rx_nib_pend_reg <= 1'b1;
         rx_nib_err_reg <= ~dec_ok;
      end else if (fall_reg) begin
         rx_nib_pend_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // receive carrier sense timer
   // ---------------------------------------------------------------
   logic [1:0] rx_tmr_reg;
   logic rx_tmr_on_reg;
   logic rx_crs_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_tmr_reg <= 2'h0;
         rx_tmr_on_reg <= 1'b0;
         rx_crs_reg <= 1'b0;
      end else if (line_rx_stb && rx_state_reg == RX_GOT_J &&
                   line_rx_code == `CODE_K) begin
         rx_tmr_reg <= 2'(`SSD_CRS_CYC);
         rx_tmr_on_reg <= 1'b1;
      end else if (line_rx_stb && rx_state_reg == RX_DATA &&
                   (line_rx_code == `CODE_T ||
                    line_rx_code == `CODE_IDLE)) begin
         rx_tmr_reg <= 2'(`ESD_CRS_CYC);
         rx_tmr_on_reg <= 1'b0;
      end else if (rx_tmr_reg != 2'h0) begin
         rx_tmr_reg <= rx_tmr_reg - 2'h1;
         if (rx_tmr_reg == 2'h1) begin
            rx_crs_reg <= rx_tmr_on_reg;
         end
      end
   end

   // receive activity holds crs up after transmit ends
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         crs <= 1'b0;
      end else begin
         crs <= tx_crs_pipe[`TX_CRS_CYC-1] | rx_crs_reg;
      end
   end

   // ---------------------------------------------------------------
   // receive pins, moved on the falling rxc edge
   // ---------------------------------------------------------------
   mii_rx_s rx_out_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_out_reg <= '0;
      end else if (fall_reg) begin
         // a pending nibble goes out on a falling edge only while rx_crs_reg is set
         if (rx_nib_pend_reg && rx_crs_reg) begin
            rx_out_reg <= '{dv: 1'b1, er: rx_nib_err_reg,
                            d: rx_nib_reg};
         end else begin
            rx_out_reg <= '0;
         end
      end
   end

   assign rx_dv = rx_out_reg.dv;
   assign rx_er = rx_out_reg.er;
   assign rxd = rx_out_reg.d;
endmodule

// *** test/mii_lat_sva.sv ***
// port assertions for the mii latency datapath
`timescale 1ns/1ps
module mii_lat_sva (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // mii side
   input wire logic txc,
   input wire logic rxc,
   input wire logic rx_dv,
   input wire logic rx_er,
   input wire logic [3:0] rxd,
   input wire logic crs,
   // line side
   input wire logic [4:0] line_tx_code,
   input wire logic line_tx_active,
   input wire logic [4:0] line_rx_code,
   input wire logic line_rx_stb
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   tx_crs_a: assert property ($rose(line_tx_active) |=> crs)
      else $error("crs late after transmit start");
   crs_drop_a: assert property ($fell(crs) |->
      !$past(line_tx_active) && ($past(line_tx_active, 2) ||
      ($past(line_rx_stb, 4) && $past(line_rx_code, 4) inside
      {5'h0D, 5'h1F})))
      else $error("crs dropped without cause");
   crs_rise_a: assert property ($rose(crs) |->
      $past(line_tx_active) ||
      ($past(line_rx_stb, 4) && $past(line_rx_code, 4) == 5'h11))
      else $error("crs rose without cause");
   tx_lat_a: assert property ($rose(line_tx_active) |->
      $past(txc, 3) && !$past(txc, 4))
      else $error("line transmit start mistimed");
   tx_idle_a: assert property (!line_tx_active |->
      line_tx_code == 5'h1F)
      else $error("line not idle");
   rx_dv_crs_a: assert property ($rose(rx_dv) |-> crs)
      else $error("receive data before crs");
   rx_edge_a: assert property ($changed({rx_dv, rx_er, rxd}) |->
      !$past(rxc) && $past(rxc, 2))
      else $error("receive pins moved off falling rxc");
   rxc_half_a: assert property ($rose(rxc) |=> rxc[*3] ##1 !rxc)
      else $error("rxc high phase wrong");
endmodule

// *** test/mii_mac_model.sv ***
// behavioural mac on the mii pins
`timescale 1ns/1ps
module mii_mac_model
   import mii_lat_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // mii
   input wire logic txc,
   input wire logic rxc,
   input wire mii_tx_s req,
   output mii_tx_s tx,
   input wire mii_rx_s rx,
   // received summary
   output logic [7:0] rx_cnt,
   output logic [7:0] rx_sum,
   output logic [3:0] rx_last
);
   logic txc_reg;
   logic rxc_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         txc_reg <= 1'b0;
         rxc_reg <= 1'b0;
         tx <= '0;
         rx_cnt <= 8'h00;
         rx_sum <= 8'h00;
         rx_last <= 4'h0;
      end else begin
         txc_reg <= txc;
         rxc_reg <= rxc;
         // change at falling txc, far from the sampling rise
         if (txc_reg && !txc) begin
            tx <= req;
            // idle nibble toggles so a stale value never passes
            if (!req.en)
               tx.d <= ~tx.d;
         end
         if (!rxc_reg && rxc && rx.dv) begin
            rx_cnt <= rx_cnt + 8'h01;
            rx_sum <= rx_sum + {4'h0, rx.d};
            rx_last <= rx.d;
         end
      end
   end
endmodule

// *** test/test_mii_tx_rx_latency.sv ***
// self-checking bench for the mii latency datapath
`timescale 1ns/1ps
module test_mii_tx_rx_latency;
   import mii_lat_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic stb = 1'b0;
   logic [4:0] code = 5'h1F;
   mii_tx_s req = '0;
   mii_tx_s tx;
   wire mii_rx_s rx;
   logic txc, rxc, crs, act;
   logic [4:0] txcode;
   logic [7:0] cnt, sum;
   logic [3:0] last;
   int error_cnt = 0;
   int checks_done = 0;
   logic [4:0] enc [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
      5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
   always #50 clk = ~clk;
   mii_tx_rx_latency dut (.clk(clk), .arst_n(arst_n), .txc(txc),
      .rxc(rxc), .tx_en(tx.en), .tx_er(tx.er), .txd(tx.d), .rx_dv(rx.dv),
      .rx_er(rx.er), .rxd(rx.d), .crs(crs), .line_tx_code(txcode),
      .line_tx_active(act), .line_rx_code(code), .line_rx_stb(stb));
   mii_mac_model mac (.clk(clk), .arst_n(arst_n), .txc(txc), .rxc(rxc),
      .req(req), .tx(tx), .rx(rx), .rx_cnt(cnt), .rx_sum(sum),
      .rx_last(last));
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      if (error_cnt == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wait_tx(input logic lvl, input logic [4:0] c);
      int i;
      for (i = 0; i < 40 && !(act === lvl && txcode === c); i++)
         step();
      chk({2'h0, act, txcode}, {2'h0, lvl, c});
      if (act !== lvl || txcode !== c)
         print_verdict();
   endtask
   task automatic tx_go(input logic er, input logic [3:0] d,
      input logic [4:0] c);
      @(posedge clk);
      req <= '{en: 1'b1, er: er, d: d};
      wait_tx(1'b1, c);
   endtask
   task automatic tx_stop(input logic fin);
      @(posedge clk);
      req <= '0;
      wait_tx(1'b0, 5'h1F);
      chk({7'h00, crs}, 8'h01);
      step();
      chk({7'h00, crs}, {7'h00, fin});
   endtask
   // one line code group, then crs looked at 2 and 3 edges on
   task automatic strobe(input logic [4:0] c, input logic on,
      input logic [1:0] e);
      @(posedge clk);
      stb <= 1'b1;
      code <= c;
      @(posedge clk);
      stb <= 1'b0;
      code <= ~c;
      #1;
      repeat (2) step();
      if (on)
         chk({7'h00, crs}, {7'h00, e[1]});
      step();
      if (on)
         chk({7'h00, crs}, {7'h00, e[0]});
      repeat (4) step();
   endtask
   task automatic t_tx();
      int n;
      tx_go(1'b0, 4'h0, enc[0]);
      chk({7'h00, crs}, 8'h00);
      step();
      chk({7'h00, crs}, 8'h01);
      for (n = 1; n < 16; n++)
         tx_go(1'b0, n[3:0], enc[n]);
      tx_go(1'b1, 4'h5, 5'h04);
      tx_stop(1'b0);
   endtask
   task automatic t_rx();
      int n;
      strobe(5'h18, 1'b0, 2'b00);
      strobe(5'h1E, 1'b1, 2'b00);
      strobe(5'h18, 1'b0, 2'b00);
      strobe(5'h11, 1'b1, 2'b01);
      for (n = 0; n < 16; n++)
         strobe(enc[n], 1'b0, 2'b00);
      strobe(5'h0D, 1'b1, 2'b10);
      repeat (16) step();
      chk(cnt, 8'h10);
      chk(sum, 8'h78);
      chk({4'h0, last}, 8'h0F);
      chk({7'h00, rx.dv}, 8'h00);
   endtask
   // transmit ends while a receive stream holds carrier
   task automatic t_both();
      int i;
      strobe(5'h18, 1'b0, 2'b00);
      strobe(5'h11, 1'b1, 2'b01);
      // a halt code inside the stream must reach the mac flagged as error
      strobe(5'h04, 1'b0, 2'b00);
      for (i = 0; i < 16 && rx.dv !== 1'b1; i++)
         step();
      chk({2'h0, rx.dv, rx.er, rx.d}, 8'h30);
      if (rx.dv !== 1'b1)
         print_verdict();
      tx_go(1'b0, 4'h3, enc[3]);
      tx_stop(1'b1);
      strobe(5'h1F, 1'b1, 2'b10);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      step();
      chk({3'h0, txcode}, 8'h1F);
      chk({5'h00, crs, rx.dv, act}, 8'h00);
      t_tx();
      t_rx();
      t_both();
      print_verdict();
   end
endmodule
bind mii_tx_rx_latency mii_lat_sva sva (.clk(clk), .arst_n(arst_n),
   .txc(txc), .rxc(rxc), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd),
   .crs(crs), .line_tx_code(line_tx_code),
   .line_tx_active(line_tx_active), .line_rx_code(line_rx_code),
   .line_rx_stb(line_rx_stb));
